/* File: logic/lin_trig_defs.svh */
// Constants of the LIN trigger decoder: register offsets, fields, reset values, timing.
// Definitions only; included by the design modules and the testbench.
`ifndef LIN_TRIG_DEFS_SVH
`define LIN_TRIG_DEFS_SVH

`define CLOCK_HZ 10000000
`define CLOCK_PERIOD_NS 100
`define WAKE_MIN_NS 250000
`define WAKE_MIN_CYC ((`WAKE_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define BREAK_MIN_BITS 11
`define BITRATE_MIN 1000
`define BITRATE_MAX 20000000
`define BITRATE_RST 9600
`define PERIOD_RST (`CLOCK_HZ / `BITRATE_RST)
`define PERIOD_MIN 4
`define DIV_STEPS 24
`define SYNC_BYTE 8'h55
`define SKIP_MAX 4096

`define ADDR_CTRL 8'h00
`define ADDR_BITRATE 8'h04
`define ADDR_IDENT 8'h08
`define ADDR_DATA 8'h0C
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h14
`define ADDR_STATE 8'h18

`define CTRL_TYPE 2:0
`define CTRL_IDLE_HIGH 3
`define CTRL_VERSION 5:4
`define CTRL_CHKS_EN 6
`define CTRL_PAR_EN 7
`define CTRL_SYNC_EN 8
`define CTRL_ID_OP 11:9
`define CTRL_DATA_OP 14:12
`define CTRL_MASK 32'h00007FFF
`define CTRL_RST 32'h000001F8
`define IDENT_LOW 5:0
`define IDENT_HIGH 13:8
`define IDENT_MASK 32'h00003F3F
`define IDENT_RST 32'h00003F00
`define DATA_PATTERN 7:0
`define DATA_SKIP 28:16
`define DATA_RST 32'h00010000

`define IRQ_TRIG 0
`define IRQ_SYNC 1
`define IRQ_PAR 2
`define IRQ_CHKS 3
`define IRQ_WAKE 4
`define IRQ_WIDTH 5

`endif

/* File: logic/lin_trig_pkg.sv */
// Types of the LIN trigger decoder.
// Offsets and counts live in lin_trig_defs.svh.
package lin_trig_pkg;

	typedef enum logic [2:0] {
		sync_field_trigger = 3'h0,
		ident_trigger = 3'h1,
		ident_and_data_trigger = 3'h2,
		wakeup_frame_trigger = 3'h3,
		error_condition_trigger = 3'h4
	} trig_kind_type;

	typedef enum logic [2:0] {
		equal_compare = 3'h0,
		not_equal_compare = 3'h1,
		less_compare = 3'h2,
		less_or_equal_compare = 3'h3,
		greater_compare = 3'h4,
		greater_or_equal_compare = 3'h5,
		inside_bounds = 3'h6,
		outside_bounds = 3'h7
	} compare_op_type;

	typedef enum logic [1:0] {
		protocol_version_one = 2'h0,
		protocol_version_two = 2'h1,
		truck_protocol_variant = 2'h2,
		auto_detect_version = 2'h3
	} version_type;

	typedef enum logic [2:0] {
		frame_idle = 3'h0,
		frame_sync = 3'h1,
		frame_ident = 3'h2,
		frame_data = 3'h3,
		frame_checksum = 3'h4
	} frame_state_type;

	typedef enum logic [2:0] {
		rx_idle = 3'h0,
		rx_start = 3'h1,
		rx_bits = 3'h2,
		rx_stop = 3'h3,
		rx_wait_high = 3'h4
	} rx_state_type;

endpackage : lin_trig_pkg

/* File: logic/lin_byte_rx.sv */
// Character receiver: start bit, eight data bits LSB first, one stop bit.
// Assumes a synchronised line where 1 is recessive, and a bit period in clocks.
`timescale 1ns/1ns
`include "lin_trig_defs.svh"

module lin_byte_rx (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Line and timing
	input wire logic line,
	input wire logic [15:0] bit_period,
	// Received character
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic stop_ok
);

	lin_trig_pkg::rx_state_type state_reg, state_next;
	logic [15:0] tick_reg, tick_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic valid_reg, valid_next;
	logic stop_reg, stop_next;
	logic expired;

	assign expired = tick_reg <= 16'h0001;

	always_comb begin
		state_next = state_reg;
		tick_next = tick_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		valid_next = 1'b0;
		stop_next = stop_reg;
		case (state_reg)
			lin_trig_pkg::rx_idle: begin
				if (!line) begin
					state_next = lin_trig_pkg::rx_start;
					tick_next = {1'b0, bit_period[15:1]};
				end
			end
			lin_trig_pkg::rx_start: begin
				// Glitch shorter than half a bit returns to idle
				if (!expired) begin
					tick_next = tick_reg - 16'h0001;
				end else if (line) begin
					state_next = lin_trig_pkg::rx_idle;
				end else begin
					state_next = lin_trig_pkg::rx_bits;
					tick_next = bit_period;
					bit_next = 4'h0;
				end
			end
			lin_trig_pkg::rx_bits: begin
				if (!expired) begin
					tick_next = tick_reg - 16'h0001;
				end else begin
					shift_next = {line, shift_reg[7:1]};
					bit_next = bit_reg + 4'h1;
					tick_next = bit_period;
					if (bit_reg == 4'h7) begin
						state_next = lin_trig_pkg::rx_stop;
					end
				end
			end
			lin_trig_pkg::rx_stop: begin
				if (!expired) begin
					tick_next = tick_reg - 16'h0001;
				end else begin
					valid_next = 1'b1;
					stop_next = line;
					state_next = line ? lin_trig_pkg::rx_idle : lin_trig_pkg::rx_wait_high;
				end
			end
			lin_trig_pkg::rx_wait_high: begin
				// A dominant stop bit must end before a new start is seen
				if (line) begin
					state_next = lin_trig_pkg::rx_idle;
				end
			end
			default: begin
				state_next = lin_trig_pkg::rx_idle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= lin_trig_pkg::rx_idle;
			tick_reg <= 16'h0000;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			valid_reg <= 1'b0;
			stop_reg <= 1'b1;
		end else if (clk_en) begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			valid_reg <= valid_next;
			stop_reg <= stop_next;
		end
	end

	assign byte_valid = valid_reg;
	assign byte_data = shift_reg;
	assign stop_ok = stop_reg;

	AST_RX_ONE_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
		valid_reg && clk_en |=> !valid_reg) else $error("character strobe longer than one cycle");

endmodule : lin_byte_rx

/* File: logic/lin_trig_decoder.sv */
// LIN trigger decoder: watches one LIN line, decodes frames, fires a trigger pulse.
// Assumes an APB master on the same 10 MHz clock and an asynchronous line pin.
//
// How it works
// - Bit rate 1000 to 20000000 bps, step one, reset value 9600.
// - Idle is recessive, read as 1; polarity picks idle-low or idle-high.
// - Version one, version two, truck variant or automatic; automatic after reset.
// - Five trigger types: sync, ident, ident plus data, wakeup, error; sync default.
// - Sync type fires on the stop bit of the sync field.
// - Ident type fires when the identifier meets its single or range condition.
// - Ident plus data fires only when both conditions hold in one frame.
// - Error type fires on checksum error if enabled; enable defaults on.
// - Error type fires on wrong parity bits 6 or 7 if enabled, default on.
// - Data compared with one pattern by six operators, equal by default.
// - Data check starts at data event number 1 to 4096, default 1.
// - Ident uses six comparisons plus inside and outside range; equal default.
// - Ident upper bound used only for inside and outside range.
// - Error type fires on a sync error if enabled, default on.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "lin_trig_defs.svh"

module lin_trig_decoder (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Observed LIN line
	input wire logic lin_pin,
	// Results
	output logic trig_out,
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Comparison shared by identifier and data conditions
	function automatic logic compare(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		case (lin_trig_pkg::compare_op_type'(op))
			lin_trig_pkg::equal_compare: compare = a == lo;
			lin_trig_pkg::not_equal_compare: compare = a != lo;
			lin_trig_pkg::less_compare: compare = a < lo;
			lin_trig_pkg::less_or_equal_compare: compare = a <= lo;
			lin_trig_pkg::greater_compare: compare = a > lo;
			lin_trig_pkg::greater_or_equal_compare: compare = a >= lo;
			lin_trig_pkg::inside_bounds: compare = a >= lo && a <= hi;
			lin_trig_pkg::outside_bounds: compare = a < lo || a > hi;
			default: compare = 1'b0;
		endcase
	endfunction : compare

	function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		add_carry = s[7:0] + {7'h00, s[8]};
	endfunction : add_carry

	function automatic logic [1:0] parity_of(input logic [5:0] id);
		parity_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
	endfunction : parity_of

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0] ctrl_reg, ctrl_next, ident_reg, ident_next, data_reg, data_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [24:0] bitrate_reg, bitrate_next;
	logic [4:0] status_reg, status_next, mask_reg, mask_next;
	logic [4:0] events;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
	logic access, wr_en, bitrate_wr;
	logic [12:0] skip_wr;
	logic pin_s1_reg, pin_s2_reg, pin_s3_reg, line_reg, line_next, line_log;
	logic [19:0] low_run_reg, low_run_next, break_cyc;
	logic break_hit, wake_hit;
	logic [15:0] period_reg, period_next;
	logic [23:0] num_reg, num_next, quo_reg, quo_next;
	logic [24:0] rem_reg, rem_next;
	logic [4:0] div_cnt_reg, div_cnt_next;
	logic div_busy;
	lin_trig_pkg::frame_state_type frame_reg, frame_next;
	lin_trig_pkg::trig_kind_type kind;
	lin_trig_pkg::version_type version;
	logic [5:0] fid_reg, fid_next;
	logic [3:0] left_reg, left_next;
	logic [12:0] pos_reg, pos_next;
	logic [7:0] sum_cl_reg, sum_cl_next, sum_en_reg, sum_en_next;
	logic id_hit_reg, id_hit_next, trig_reg, trig_next;
	logic rx_valid, rx_stop;
	logic [7:0] rx_byte;
	logic id_match, data_match, data_check, cl_ok, en_ok, chks_ok;
	logic sync_err, par_err, chk_err, fire;

	assign kind = lin_trig_pkg::trig_kind_type'(ctrl_reg[`CTRL_TYPE]);
	assign version = lin_trig_pkg::version_type'(ctrl_reg[`CTRL_VERSION]);

	////////////////////////////////////////////////////////////////////////////////
	// APB registers and interrupt; one wait state so prdata comes from a flop
	assign access = psel && penable && !pready_reg;
	assign wr_en = psel && penable && pready_reg && pwrite;
	assign events = {wake_hit, chk_err, par_err, sync_err, trig_next};
	assign skip_wr = pwdata[`DATA_SKIP];

	always_comb begin
		ctrl_next = ctrl_reg;
		ident_next = ident_reg;
		data_next = data_reg;
		bitrate_next = bitrate_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		bitrate_wr = 1'b0;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		pready_next = access;
		if (access) begin
			pslverr_next = 1'b0;
			case (paddr)
				`ADDR_CTRL: prdata_next = ctrl_reg;
				`ADDR_BITRATE: prdata_next = {7'h00, bitrate_reg};
				`ADDR_IDENT: prdata_next = ident_reg;
				`ADDR_DATA: prdata_next = data_reg;
				`ADDR_IRQ_STATUS: prdata_next = {27'h0000000, status_reg};
				`ADDR_IRQ_MASK: prdata_next = {27'h0000000, mask_reg};
				`ADDR_STATE: prdata_next = {div_busy, 7'h00, rx_byte, 2'h0, fid_reg,
					5'h00, frame_reg};
				default: begin
					prdata_next = 32'h00000000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (wr_en) begin
			case (paddr)
				`ADDR_CTRL: ctrl_next = pwdata & `CTRL_MASK;
				`ADDR_BITRATE: begin
					bitrate_wr = 1'b1;
					if (pwdata < `BITRATE_MIN) begin
						bitrate_next = 25'(`BITRATE_MIN);
					end else if (pwdata > `BITRATE_MAX) begin
						bitrate_next = 25'(`BITRATE_MAX);
					end else begin
						bitrate_next = pwdata[24:0];
					end
				end
				`ADDR_IDENT: ident_next = pwdata & `IDENT_MASK;
				`ADDR_DATA: begin
					data_next = {19'h00000, 5'h00, pwdata[`DATA_PATTERN]};
					if (skip_wr == 13'h0000) begin
						data_next[`DATA_SKIP] = 13'h0001;
					end else if (skip_wr > 13'(`SKIP_MAX)) begin
						data_next[`DATA_SKIP] = 13'(`SKIP_MAX);
					end else begin
						data_next[`DATA_SKIP] = skip_wr;
					end
				end
				`ADDR_IRQ_STATUS: status_next = status_reg & ~pwdata[4:0];
				`ADDR_IRQ_MASK: mask_next = pwdata[4:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
		// A new event wins over a clear in the same cycle
		status_next = status_next | events;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= `CTRL_RST;
			ident_reg <= `IDENT_RST;
			data_reg <= `DATA_RST;
			bitrate_reg <= 25'(`BITRATE_RST);
			mask_reg <= 5'h00;
			status_reg <= 5'h00;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
			pready_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			ident_reg <= ident_next;
			data_reg <= data_next;
			bitrate_reg <= bitrate_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			pready_reg <= pready_next;
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit period = clock rate / bit rate, serial division to avoid a wide divider
	assign div_busy = div_cnt_reg != 5'h00;

	always_comb begin
		logic [24:0] rem_sh;
		logic [23:0] q_new;
		rem_sh = {rem_reg[23:0], num_reg[23]};
		q_new = {quo_reg[22:0], 1'b0};
		num_next = num_reg;
		rem_next = rem_reg;
		quo_next = quo_reg;
		div_cnt_next = div_cnt_reg;
		period_next = period_reg;
		if (bitrate_wr) begin
			num_next = 24'(`CLOCK_HZ);
			rem_next = 25'h0000000;
			quo_next = 24'h000000;
			div_cnt_next = 5'(`DIV_STEPS);
		end else if (div_busy) begin
			num_next = {num_reg[22:0], 1'b0};
			rem_next = rem_sh;
			if (rem_sh >= bitrate_reg) begin
				rem_next = rem_sh - bitrate_reg;
				q_new[0] = 1'b1;
			end
			quo_next = q_new;
			div_cnt_next = div_cnt_reg - 5'h01;
			// Fast rates would leave too few clocks per bit; floor the period
			if (div_cnt_reg == 5'h01) begin
				period_next = (q_new < 24'(`PERIOD_MIN)) ? 16'(`PERIOD_MIN) : q_new[15:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			num_reg <= 24'h000000;
			rem_reg <= 25'h0000000;
			quo_reg <= 24'h000000;
			div_cnt_reg <= 5'h00;
			period_reg <= 16'(`PERIOD_RST);
		end else if (clk_en) begin
			num_reg <= num_next;
			rem_reg <= rem_next;
			quo_reg <= quo_next;
			div_cnt_reg <= div_cnt_next;
			period_reg <= period_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser, polarity, break and wakeup detection by dominant length
	assign line_log = ctrl_reg[`CTRL_IDLE_HIGH] ? line_reg : ~line_reg;
	assign break_cyc = 20'(`BREAK_MIN_BITS) * {4'h0, period_reg};
	assign break_hit = line_log && low_run_reg >= break_cyc;
	assign wake_hit = line_log && frame_reg == lin_trig_pkg::frame_idle &&
		low_run_reg >= 20'(`WAKE_MIN_CYC) && low_run_reg < break_cyc;

	always_comb begin
		line_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : line_reg;
		low_run_next = 20'h00000;
		if (!line_log) begin
			low_run_next = (low_run_reg == 20'hFFFFF) ? low_run_reg : low_run_reg + 20'h00001;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_s3_reg <= 1'b1;
			line_reg <= 1'b1;
			low_run_reg <= 20'h00000;
		end else if (clk_en) begin
			pin_s1_reg <= lin_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			line_reg <= line_next;
			low_run_reg <= low_run_next;
		end
	end

	lin_byte_rx i_lin_byte_rx (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.line(line_log),
		.bit_period(period_reg),
		.byte_valid(rx_valid),
		.byte_data(rx_byte),
		.stop_ok(rx_stop)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Frame decoder and trigger
	assign id_match = compare(ctrl_reg[`CTRL_ID_OP], {2'h0, rx_byte[5:0]},
		{2'h0, ident_reg[`IDENT_LOW]}, {2'h0, ident_reg[`IDENT_HIGH]});
	assign data_check = pos_reg >= data_reg[`DATA_SKIP];
	assign data_match = compare(ctrl_reg[`CTRL_DATA_OP], rx_byte,
		data_reg[`DATA_PATTERN], data_reg[`DATA_PATTERN]);
	assign cl_ok = rx_byte == ~sum_cl_reg;
	assign en_ok = rx_byte == ~sum_en_reg;

	always_comb begin
		case (version)
			lin_trig_pkg::protocol_version_one: chks_ok = cl_ok;
			lin_trig_pkg::protocol_version_two,
			lin_trig_pkg::truck_protocol_variant: chks_ok = (fid_reg >= 6'h3C) ? cl_ok : en_ok;
			default: chks_ok = cl_ok || en_ok;
		endcase
	end

	always_comb begin
		frame_next = frame_reg;
		fid_next = fid_reg;
		left_next = left_reg;
		pos_next = pos_reg;
		sum_cl_next = sum_cl_reg;
		sum_en_next = sum_en_reg;
		id_hit_next = id_hit_reg;
		sync_err = 1'b0;
		par_err = 1'b0;
		chk_err = 1'b0;
		fire = 1'b0;
		if (break_hit) begin
			frame_next = lin_trig_pkg::frame_sync;
		end else if (rx_valid) begin
			case (frame_reg)
				lin_trig_pkg::frame_sync: begin
					if (rx_byte == `SYNC_BYTE && rx_stop) begin
						frame_next = lin_trig_pkg::frame_ident;
						fire = kind == lin_trig_pkg::sync_field_trigger;
					end else begin
						sync_err = 1'b1;
					end
				end
				lin_trig_pkg::frame_ident: begin
					fid_next = rx_byte[5:0];
					par_err = rx_byte[7:6] != parity_of(rx_byte[5:0]);
					id_hit_next = id_match;
					fire = kind == lin_trig_pkg::ident_trigger && id_match;
					sum_cl_next = 8'h00;
					sum_en_next = rx_byte;
					pos_next = 13'h0001;
					left_next = rx_byte[5] ? (rx_byte[4] ? 4'h8 : 4'h4) : 4'h2;
					frame_next = lin_trig_pkg::frame_data;
				end
				lin_trig_pkg::frame_data: begin
					sum_cl_next = add_carry(sum_cl_reg, rx_byte);
					sum_en_next = add_carry(sum_en_reg, rx_byte);
					fire = kind == lin_trig_pkg::ident_and_data_trigger &&
						id_hit_reg && data_check && data_match;
					pos_next = pos_reg + 13'h0001;
					left_next = left_reg - 4'h1;
					if (left_reg == 4'h1) begin
						frame_next = lin_trig_pkg::frame_checksum;
					end
				end
				lin_trig_pkg::frame_checksum: begin
					chk_err = !chks_ok;
					frame_next = lin_trig_pkg::frame_idle;
				end
				default: frame_next = lin_trig_pkg::frame_idle;
			endcase
			if (!rx_stop || sync_err) begin
				frame_next = lin_trig_pkg::frame_idle;
			end
		end
		if (kind == lin_trig_pkg::error_condition_trigger) begin
			fire = (chk_err && ctrl_reg[`CTRL_CHKS_EN]) ||
				(par_err && ctrl_reg[`CTRL_PAR_EN]) ||
				(sync_err && ctrl_reg[`CTRL_SYNC_EN]);
		end
		if (kind == lin_trig_pkg::wakeup_frame_trigger) begin
			fire = wake_hit;
		end
		trig_next = fire;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frame_reg <= lin_trig_pkg::frame_idle;
			fid_reg <= 6'h00;
			left_reg <= 4'h0;
			pos_reg <= 13'h0000;
			sum_cl_reg <= 8'h00;
			sum_en_reg <= 8'h00;
			id_hit_reg <= 1'b0;
			trig_reg <= 1'b0;
		end else if (clk_en) begin
			frame_reg <= frame_next;
			fid_reg <= fid_next;
			left_reg <= left_next;
			pos_reg <= pos_next;
			sum_cl_reg <= sum_cl_next;
			sum_en_reg <= sum_en_next;
			id_hit_reg <= id_hit_next;
			trig_reg <= trig_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign trig_out = trig_reg;
	assign irq_out = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_BITRATE_RANGE: assert property (bitrate_reg >= 25'(`BITRATE_MIN) &&
		bitrate_reg <= 25'(`BITRATE_MAX)) else $error("bit rate out of range");
	AST_TRIG_PULSE: assert property (trig_reg && clk_en |=> !trig_reg)
		else $error("trigger longer than one cycle");
	AST_SYNC_FIRE: assert property (clk_en && rx_valid && !break_hit &&
		frame_reg == lin_trig_pkg::frame_sync && rx_byte == `SYNC_BYTE && rx_stop &&
		kind == lin_trig_pkg::sync_field_trigger |=> trig_reg) else $error("sync trigger missed");
	AST_ID_FIRE: assert property (clk_en && rx_valid && !break_hit && rx_stop &&
		frame_reg == lin_trig_pkg::frame_ident && kind == lin_trig_pkg::ident_trigger &&
		id_match |=> trig_reg) else $error("ident trigger missed");
	AST_IDENT_AND_DATA_TRIGGER_NEEDS_ID: assert property (trig_reg &&
		kind == lin_trig_pkg::ident_and_data_trigger |-> $past(id_hit_reg))
		else $error("data trigger without ident match");
	AST_CHKS_FIRE: assert property (clk_en && chk_err && ctrl_reg[`CTRL_CHKS_EN] &&
		kind == lin_trig_pkg::error_condition_trigger |=> trig_reg)
		else $error("checksum trigger missed");
	AST_PAR_FIRE: assert property (clk_en && par_err && ctrl_reg[`CTRL_PAR_EN] &&
		kind == lin_trig_pkg::error_condition_trigger |=> trig_reg)
		else $error("parity trigger missed");
	AST_SYNC_ERR_FIRE: assert property (clk_en && sync_err && ctrl_reg[`CTRL_SYNC_EN] &&
		kind == lin_trig_pkg::error_condition_trigger |=> trig_reg)
		else $error("sync error trigger missed");
	AST_HIGH_IGNORED: assert property (ctrl_reg[11:9] < 3'h6 |->
		compare(ctrl_reg[11:9], {2'h0, rx_byte[5:0]}, {2'h0, ident_reg[5:0]}, 8'h00) ==
		compare(ctrl_reg[11:9], {2'h0, rx_byte[5:0]}, {2'h0, ident_reg[5:0]}, 8'h3F))
		else $error("upper ident bound used outside range mode");
	AST_SKIP: assert property (clk_en && trig_reg &&
		kind == lin_trig_pkg::ident_and_data_trigger |-> $past(pos_reg) >= data_reg[`DATA_SKIP])
		else $error("data checked before skip count");

	COV_SYNC: cover property (trig_reg && kind == lin_trig_pkg::sync_field_trigger);
	COV_IDENT_AND_DATA_TRIGGER: cover property (trig_reg && kind == lin_trig_pkg::ident_and_data_trigger);
	COV_CHKS: cover property (chk_err ##1 irq_reg);
	COV_WAKE: cover property (wake_hit);

endmodule : lin_trig_decoder

/* File: tb/lin_node_model.sv */
// LIN node model: break, sync, protected ident, data bytes, classic checksum.
// Assumes idle-high polarity; the pulled-up line rests recessive high.
`timescale 1ns/1ns

module lin_node_model #(
	parameter int BIT_CLKS = 100
) (
	// Clock
	input wire logic clock,
	// Bus line
	output logic line
);
	initial line = 1'b1;

	task automatic put(input logic b, input int n);
		line <= b;
		repeat (n * BIT_CLKS) @(posedge clock);
	endtask : put

	task automatic put_byte(input logic [7:0] v);
		put(1'b0, 1);
		for (int i = 0; i < 8; i++) put(v[i], 1);
		put(1'b1, 1);
	endtask : put_byte

	task automatic send_frame(input logic [5:0] id, input logic bad_par);
		logic [7:0] pid;
		logic [7:0] c;
		logic [8:0] s;
		int n;
		pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		// Flip only the top parity bit when a fault is wanted
		pid[7] = pid[7] ^ bad_par;
		n = (id < 32) ? 2 : ((id < 48) ? 4 : 8);
		c = 8'h00;
		put(1'b0, 13);
		put(1'b1, 1);
		put_byte(8'h55);
		put_byte(pid);
		for (int i = 0; i < n; i++) begin
			s = c + (8'hA0 + i[7:0]);
			c = s[7:0] + {7'h00, s[8]};
			put_byte(8'hA0 + i[7:0]);
		end
		put_byte(~c);
	endtask : send_frame
endmodule : lin_node_model

/* File: tb/lin_trig_decoder_tb.sv */
// Self-checking bench of the LIN trigger decoder over APB.
// Assumes the line model above; rate set to 100000 bps (100 clocks a bit), then 10000 bps for the wakeup test.
`timescale 1ns/1ns
`include "lin_trig_defs.svh"

module lin_trig_decoder_tb;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, trig_out, irq_out, lin_pin;
	logic er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int mismatches = 0;
	int num_checks = 0;
	int trigs = 0;
	int cycles = 0;

	lin_node_model #(.BIT_CLKS(100)) i_lin_node_model (.clock(clock), .line(lin_pin));
	lin_trig_decoder i_lin_trig_decoder (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lin_pin(lin_pin),
		.trig_out(trig_out), .irq_out(irq_out));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Sampled mid-cycle so edge updates have landed
	always @(negedge clock) begin
		cycles++;
		if (trig_out === 1'b1) trigs++;
		if (cycles == 70000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (mismatches == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		@(posedge clock);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task automatic frame(input logic [5:0] id, input logic bad, input int exp);
		int t0;
		t0 = trigs;
		i_lin_node_model.send_frame(id, bad);
		repeat (300) @(posedge clock);
		chk("trigger count", exp, trigs - t0);
	endtask : frame

	task automatic t_reset();
		apb(1'b0, `ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h000001F8, rd);
		apb(1'b0, `ADDR_BITRATE, 32'h0);
		chk("bitrate", 32'd9600, rd);
		apb(1'b0, `ADDR_DATA, 32'h0);
		chk("data", 32'h00010000, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
	endtask : t_reset

	task automatic t_rate();
		apb(1'b1, `ADDR_BITRATE, 32'd500);
		apb(1'b0, `ADDR_BITRATE, 32'h0);
		chk("bitrate clamp", 32'd1000, rd);
		apb(1'b1, `ADDR_BITRATE, 32'd100000);
		// Divider needs 24 cycles for the new period
		repeat (30) @(posedge clock);
	endtask : t_rate

	task automatic t_sync();
		apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
		frame(6'h05, 1'b0, 1);
		chk("irq set", 32'h1, {31'h0, irq_out});
		apb(1'b1, `ADDR_IRQ_STATUS, 32'h1F);
		@(negedge clock);
		chk("irq cleared", 32'h0, {31'h0, irq_out});
	endtask : t_sync

	task automatic t_ident();
		apb(1'b1, `ADDR_CTRL, 32'h00000DF9);
		apb(1'b1, `ADDR_IDENT, 32'h00002010);
		frame(6'h15, 1'b0, 1);
		frame(6'h25, 1'b0, 0);
	endtask : t_ident

	task automatic t_err();
		apb(1'b1, `ADDR_CTRL, 32'h000001FC);
		frame(6'h05, 1'b0, 0);
		frame(6'h05, 1'b1, 1);
		apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
		chk("parity status", 32'h1, {31'h0, rd[`IRQ_PAR]});
	endtask : t_err

	task automatic t_data();
		apb(1'b1, `ADDR_CTRL, 32'h00005DFA);
		apb(1'b1, `ADDR_DATA, 32'h000200A0);
		frame(6'h15, 1'b0, 1);
		frame(6'h05, 1'b0, 0);
	endtask : t_data

	task automatic t_wake();
		int t0;
		apb(1'b1, `ADDR_BITRATE, 32'd10000);
		repeat (30) @(posedge clock);
		apb(1'b1, `ADDR_CTRL, 32'h000001FB);
		t0 = trigs;
		// Dominant 3000 clocks: above the wakeup minimum, far below a break at 1000 a bit
		i_lin_node_model.put(1'b0, 30);
		i_lin_node_model.put(1'b1, 1);
		chk("wakeup trigger count", 1, trigs - t0);
		apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
		chk("wakeup status", 32'h1, {31'h0, rd[`IRQ_WAKE]});
	endtask : t_wake

	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_rate();
		t_sync();
		t_ident();
		t_err();
		t_data();
		t_wake();
		end_sim();
	end
endmodule : lin_trig_decoder_tb
